// [common/cck_defines.svh]
`ifndef CCK_DEFINES_SVH
`define CCK_DEFINES_SVH

// register offsets on the control port
`define CCK_OFS_GP_SRC        8'h46
`define CCK_OFS_GP_DIV        8'h47
`define CCK_OFS_CONV          8'h49

// reset values
`define CCK_RST_GP_SRC        3'h0
`define CCK_RST_GP_DIV        8'h01
`define CCK_RST_CONV          8'h00
`define CCK_RST_RDATA         8'h00

// field positions
`define CCK_GP_EN_BIT         7
`define CCK_GP_DIV_HI         6
`define CCK_CONV_FREQ_HI      7
`define CCK_CONV_FREQ_LO      6
`define CCK_CONV_SRC_AUTO_BIT 5
`define CCK_CONV_PICK_BIT     4
`define CCK_CONV_EN_AUTO_BIT  3
`define CCK_CONV_MAN_EN_BIT   2
`define CCK_CONV_RATIO_HI     1

// source codes of the general clock mux
`define CCK_SRC_PLL           3'h0
`define CCK_SRC_PRI_BIT       3'h1
`define CCK_SRC_SEC_BIT       3'h2
`define CCK_SRC_CTRL          3'h3
`define CCK_SRC_OSC           3'h4
`define CCK_SRC_DSP           3'h5

// sync slot of the converter audio clock, frequency code needing the osc
`define CCK_SYNC_AUDIO        6
`define CCK_SYNC_OSC          4
`define CCK_FREQ_12M          2'h3

`endif

// [common/cck_pkg.sv]
package cck_pkg;

    // complete state of the configuration top
    typedef struct packed {
        logic [2:0] gp_src;
        logic [7:0] gp_div;
        logic [7:0] conv;
        logic [7:0] rdata;
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic       mode_err;
    } cck_state_t;

    // complete state of one divider
    typedef struct packed {
        logic       prev;
        logic [7:0] cnt;
        logic       out;
    } cck_div_state_t;

endpackage

// [design/cck_clk_divider.sv]
`timescale 1ns/10ps
`default_nettype none

module cck_clk_divider
    import cck_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       src_i,
    input  wire logic       en_i,
    input  wire logic [7:0] ratio_i,
    output logic            clk_o
);

    cck_div_state_t st_r;
    cck_div_state_t st_nxt;
    logic           rise;

    // count source rising edges; out high while the count is below half the ratio, rounded down; ratio 1 passes the source through
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = src_i;
        rise = src_i & ~st_r.prev;
        if (!en_i) begin
            // static low, no runt pulse since out is a flop
            st_nxt.cnt = 8'h00;
            st_nxt.out = 1'b0;
        end else begin
            if (st_r.cnt >= ratio_i) begin
                // ratio shrank under the count: restart at once
                st_nxt.cnt = 8'h00;
            end else if (rise) begin
                if (st_r.cnt >= ratio_i - 8'h01) begin
                    st_nxt.cnt = 8'h00;
                end else begin
                    st_nxt.cnt = st_r.cnt + 8'h01;
                end
            end
            if (ratio_i == 8'h01) begin
                st_nxt.out = src_i;
            end else begin
                st_nxt.out = (st_nxt.cnt < (ratio_i >> 1));
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign clk_o = st_r.out;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    off_low_a: assert property (!en_i |=> !clk_o) // R11
        else $error("divider output not low while disabled");
    cnt_range_a: assert property (en_i && $past(en_i)
                                  |-> st_r.cnt < ratio_i || $changed(ratio_i))
        else $error("divider count beyond ratio");
    run_cov_c: cover property (en_i ##1 $rose(clk_o));

endmodule

`default_nettype wire

// [design/cck_clock_config.sv]
`timescale 1ns/10ps
`default_nettype none

`include "cck_defines.svh"

// Behaviour
// R1: codes 0..5 pick pll, two bit clocks, control, osc, dsp; 6, 7 reserved.
// R2: the general divider runs only while its enable bit is 1.
// R3: the seven-bit divide field gives 128 at zero, else its own value.
// R4: frequency mode 0..3 is about 6, 3, 1.5, 12 MHz; 3 needs direct osc.
// R5: with source auto-disable at 0 the source follows clock detection.
// R6: manual pick 0 takes the audio clock, 1 the osc; ignored in auto mode.
// R7: with enable auto-disable at 0 the divider is enabled automatically.
// R8: in manual mode the manual enable bit turns the divider on or off.
// R9: manual ratio codes 0..3 give 1, 2, 4, 8; ignored in auto mode.
// R10: the upper five source register bits are read-only and read zero.
// R11: a disabled divider or reserved source holds the output static low.
module cck_clock_config
    import cck_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       RSTN_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic       REG_WE_I,
    input  wire logic       REG_RE_I,
    output logic      [7:0] REG_RDATA_O,
    input  wire logic       PLL_CLK_I,
    input  wire logic       PRI_BIT_CLK_I,
    input  wire logic       SEC_BIT_CLK_I,
    input  wire logic       CTRL_CLK_I,
    input  wire logic       OSC_CLK_I,
    input  wire logic       DSP_CLK_I,
    input  wire logic       AUDIO_CLK_I,
    input  wire logic       CONV_DET_OSC_I,
    input  wire logic [1:0] CONV_DET_RATIO_I,
    output logic            GP_CLK_O,
    output logic            CONV_CLK_O,
    output logic      [1:0] CONV_FREQ_MODE_O,
    output logic            CONV_MODE_ERR_O
);

    cck_state_t st_r;
    cck_state_t st_nxt;
    logic       gp_src_lvl;
    logic       gp_run;
    logic [7:0] gp_ratio;
    logic       conv_auto_src;
    logic       conv_auto_en;
    logic       conv_use_osc;
    logic       conv_src_lvl;
    logic       conv_run;
    logic [7:0] conv_ratio;

    // zero in the field stands for the largest ratio
    function automatic logic [7:0] gp_ratio_f(input logic [6:0] code);
        gp_ratio_f = (code == 7'h00) ? 8'h80 : {1'b0, code};
    endfunction

    // power-of-two ratio from a two-bit code
    function automatic logic [7:0] conv_ratio_f(input logic [1:0] code);
        conv_ratio_f = 8'h01 << code;
    endfunction

    // general clock mux; reserved codes leave the divider stopped
    always_comb begin
        gp_src_lvl = 1'b0;
        gp_run     = st_r.gp_div[`CCK_GP_EN_BIT]; // R2
        unique case (st_r.gp_src) // R1
            `CCK_SRC_PLL:     gp_src_lvl = st_r.sync2[0];
            `CCK_SRC_PRI_BIT: gp_src_lvl = st_r.sync2[1];
            `CCK_SRC_SEC_BIT: gp_src_lvl = st_r.sync2[2];
            `CCK_SRC_CTRL:    gp_src_lvl = st_r.sync2[3];
            `CCK_SRC_OSC:     gp_src_lvl = st_r.sync2[4];
            `CCK_SRC_DSP:     gp_src_lvl = st_r.sync2[5];
            default:          gp_run = 1'b0; // R11
        endcase
        gp_ratio = gp_ratio_f(st_r.gp_div[`CCK_GP_DIV_HI:0]); // R3
    end

    // converter clock: source auto mode overrides the pick, enable auto mode the enable and ratio
    always_comb begin
        conv_auto_src = ~st_r.conv[`CCK_CONV_SRC_AUTO_BIT]; // R5
        conv_auto_en  = ~st_r.conv[`CCK_CONV_EN_AUTO_BIT]; // R7
        conv_use_osc  = conv_auto_src ? CONV_DET_OSC_I
                                      : st_r.conv[`CCK_CONV_PICK_BIT]; // R6
        conv_src_lvl  = conv_use_osc ? st_r.sync2[`CCK_SYNC_OSC]
                                     : st_r.sync2[`CCK_SYNC_AUDIO];
        conv_run      = conv_auto_en ? 1'b1
                                     : st_r.conv[`CCK_CONV_MAN_EN_BIT]; // R8
        conv_ratio    = conv_auto_en
                      ? conv_ratio_f(CONV_DET_RATIO_I)
                      : conv_ratio_f(st_r.conv[`CCK_CONV_RATIO_HI:0]); // R9
    end

    // register port, pin synchronisers and the mode check
    always_comb begin
        st_nxt = st_r;
        // first stage feeds only the second stage
        st_nxt.sync1 = {AUDIO_CLK_I, DSP_CLK_I, OSC_CLK_I, CTRL_CLK_I,
                        SEC_BIT_CLK_I, PRI_BIT_CLK_I, PLL_CLK_I};
        st_nxt.sync2 = st_r.sync1;
        if (REG_WE_I) begin
            unique case (REG_ADDR_I)
                `CCK_OFS_GP_SRC: st_nxt.gp_src = REG_WDATA_I[2:0]; // R10
                `CCK_OFS_GP_DIV: st_nxt.gp_div = REG_WDATA_I;
                `CCK_OFS_CONV:   st_nxt.conv   = REG_WDATA_I;
                default:         st_nxt.gp_src = st_r.gp_src;
            endcase
        end
        if (REG_RE_I) begin
            unique case (REG_ADDR_I)
                `CCK_OFS_GP_SRC: st_nxt.rdata = {5'h00, st_r.gp_src}; // R10
                `CCK_OFS_GP_DIV: st_nxt.rdata = st_r.gp_div;
                `CCK_OFS_CONV:   st_nxt.rdata = st_r.conv;
                default:         st_nxt.rdata = 8'h00; // unmapped reads zero
            endcase
        end
        // 12 MHz mode is flagged unless the oscillator is picked by hand
        st_nxt.mode_err =
            (st_r.conv[`CCK_CONV_FREQ_HI:`CCK_CONV_FREQ_LO] == `CCK_FREQ_12M)
            && !(!conv_auto_src && conv_use_osc); // R4
    end

    // state register; the async branch loads constants only
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st_r.gp_src   <= `CCK_RST_GP_SRC;
            st_r.gp_div   <= `CCK_RST_GP_DIV;
            st_r.conv     <= `CCK_RST_CONV;
            st_r.rdata    <= `CCK_RST_RDATA;
            st_r.sync1    <= 7'h00;
            st_r.sync2    <= 7'h00;
            st_r.mode_err <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // both dividers share one structure; output flops live inside
    cck_clk_divider u_gp_div (
        .clk_i   (CLK_I),
        .rstn_i  (RSTN_I),
        .src_i   (gp_src_lvl),
        .en_i    (gp_run),
        .ratio_i (gp_ratio),
        .clk_o   (GP_CLK_O)
    );

    cck_clk_divider u_conv_div (
        .clk_i   (CLK_I),
        .rstn_i  (RSTN_I),
        .src_i   (conv_src_lvl),
        .en_i    (conv_run),
        .ratio_i (conv_ratio),
        .clk_o   (CONV_CLK_O)
    );

    assign REG_RDATA_O      = st_r.rdata;
    assign CONV_FREQ_MODE_O = st_r.conv[`CCK_CONV_FREQ_HI:`CCK_CONV_FREQ_LO];
    assign CONV_MODE_ERR_O  = st_r.mode_err;

    // checks on decode, clock gating and the mode flag
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    src_mux_a: assert property ( // R1
        st_r.gp_src == `CCK_SRC_OSC |-> gp_src_lvl == st_r.sync2[4])
        else $error("general source mux picked wrong clock");
    gp_stop_a: assert property ( // R2
        !st_r.gp_div[`CCK_GP_EN_BIT] |=> !GP_CLK_O)
        else $error("general clock output runs while disabled");
    gp_ratio_a: assert property ( // R3
        st_r.gp_div[`CCK_GP_DIV_HI:0] == 7'h00 |-> gp_ratio == 8'h80)
        else $error("zero divide field not 128");
    mode_flag_a: assert property ( // R4
        st_r.conv[7:6] == 2'h3 && st_r.conv[5] == 1'b0 |=> CONV_MODE_ERR_O)
        else $error("12 MHz mode in auto source not flagged");
    auto_src_a: assert property ( // R5
        !st_r.conv[5] |-> conv_use_osc == CONV_DET_OSC_I)
        else $error("auto source not from detection");
    man_src_a: assert property ( // R6
        st_r.conv[5] |-> conv_use_osc == st_r.conv[4])
        else $error("manual source pick ignored");
    auto_en_a: assert property ( // R7
        !st_r.conv[3] |-> conv_run)
        else $error("converter divider not auto enabled");
    man_en_a: assert property ( // R8
        st_r.conv[3] && !st_r.conv[2] |=> !CONV_CLK_O)
        else $error("converter clock runs with manual enable low");
    man_ratio_a: assert property ( // R9
        st_r.conv[3] && st_r.conv[1:0] == 2'h3 |-> conv_ratio == 8'h08)
        else $error("manual ratio code 3 not 8");
    rsvd_read_a: assert property ( // R10
        REG_RE_I && REG_ADDR_I == `CCK_OFS_GP_SRC
        |=> REG_RDATA_O[7:3] == 5'h00)
        else $error("reserved source bits read nonzero");
    rsvd_off_a: assert property ( // R11
        (st_r.gp_src > `CCK_SRC_DSP) [*2] |-> !GP_CLK_O)
        else $error("reserved source does not hold output low");
    wr_land_a: assert property ( // R10
        REG_WE_I && REG_ADDR_I == `CCK_OFS_GP_SRC
        |=> st_r.gp_src == $past(REG_WDATA_I[2:0]))
        else $error("source select write lost");
    gp_rsvd_run_a: assert property ( // R11
        st_r.gp_src > `CCK_SRC_DSP |-> !gp_run)
        else $error("general divider runs on reserved source");
    gp_ratio_max_a: assert property ( // R3
        st_r.gp_div[`CCK_GP_DIV_HI:0] == 7'h7f |-> gp_ratio == 8'h7f)
        else $error("divide field 127 not 127");
    man_ratio_one_a: assert property ( // R9
        st_r.conv[3] && st_r.conv[1:0] == 2'h1 |-> conv_ratio == 8'h02)
        else $error("manual ratio code 1 not 2");
    mode_ok_a: assert property ( // R4
        st_r.conv[7:6] == 2'h3 && st_r.conv[5:4] == 2'h3 |=> !CONV_MODE_ERR_O)
        else $error("12 MHz mode on manual osc flagged");

    gp_run_c: cover property (gp_run ##1 $rose(GP_CLK_O));
    conv_osc_c: cover property (
        conv_use_osc && conv_run ##1 $rose(CONV_CLK_O));
    mode_err_c: cover property ($rose(CONV_MODE_ERR_O));
    reg_wr_c: cover property (REG_WE_I && REG_ADDR_I == `CCK_OFS_GP_DIV);

endmodule

`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/10ps
`default_nettype none

`include "cck_defines.svh"

module testbench
    import cck_pkg::*;
;
    logic       clk;
    logic       rstn;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
    logic [7:0] rdata;
    logic [6:0] src;
    logic       det_osc;
    logic [1:0] det_ratio;
    logic       gp_clk;
    logic       conv_clk;
    logic [1:0] freq_mode;
    logic       mode_err;
    int         miscompares;
    int         checks;

    cck_clock_config i_dut (
        .CLK_I           (clk),
        .RSTN_I          (rstn),
        .REG_ADDR_I      (addr),
        .REG_WDATA_I     (wdata),
        .REG_WE_I        (we),
        .REG_RE_I        (re),
        .REG_RDATA_O     (rdata),
        .PLL_CLK_I       (src[0]),
        .PRI_BIT_CLK_I   (src[1]),
        .SEC_BIT_CLK_I   (src[2]),
        .CTRL_CLK_I      (src[3]),
        .OSC_CLK_I       (src[4]),
        .DSP_CLK_I       (src[5]),
        .AUDIO_CLK_I     (src[6]),
        .CONV_DET_OSC_I  (det_osc),
        .CONV_DET_RATIO_I(det_ratio),
        .GP_CLK_O        (gp_clk),
        .CONV_CLK_O      (conv_clk),
        .CONV_FREQ_MODE_O(freq_mode),
        .CONV_MODE_ERR_O (mode_err)
    );

    // 200 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // source k has a period of 2*(k+4) system cycles, all distinct
    // one process drives every source, toggling on the falling edge
    initial begin
        int t;
        t = 0;
        src = 7'h00;
        forever begin
            #5 t++;
            for (int k = 0; k < 7; k++) begin
                if (t % (k + 4) == 0) src[k] = ~src[k];
            end
        end
    end

    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 we = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1 we = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 re = 1'b1;
        addr = a;
        @(posedge clk);
        #1 re = 1'b0;
        cmp8(rdata, exp);
    endtask

    // rise-to-rise period in system cycles; 0 when the output never rises
    // the first rise after a change is skipped as it may be a partial one
    task automatic measure(input bit conv, input int exp);
        int   n;
        int   t0;
        int   r;
        int   per;
        logic prev;
        logic cur;
        n = 0;
        t0 = 0;
        r = 0;
        prev = 1'b1;
        while (n < 3 * exp + 500 && r < 3) begin
            @(posedge clk);
            #1 cur = conv ? conv_clk : gp_clk;
            n++;
            if (cur === 1'b1 && prev !== 1'b1) begin
                r++;
                if (r == 2) t0 = n;
            end
            prev = cur;
        end
        per = (r == 3) ? n - t0 : 0;
        checks++;
        if (per > exp + 1 || per < exp - 1) begin
            miscompares++;
            $display("[ERR] %0t period %0d expected %0d", $time, per, exp);
        end
    endtask

    // hang guard, far beyond the planned run of about 55 us
    initial begin
        #400000;
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        miscompares = 0;
        checks = 0;
        rstn = 1'b0;
        {addr, wdata, we, re} = 18'h0;
        det_osc = 1'b0;
        det_ratio = 2'h0;
        repeat (16) @(posedge clk);
        #1 rstn = 1'b1;
        // reset values and read-only upper bits of the source register
        rd(`CCK_OFS_GP_SRC, 8'h00);
        rd(`CCK_OFS_GP_DIV, 8'h01);
        rd(`CCK_OFS_CONV, 8'h00);
        wr(`CCK_OFS_GP_SRC, 8'hfd);
        rd(`CCK_OFS_GP_SRC, 8'h05);
        rd(8'h48, 8'h00);
        // every source code, odd ratio 3, writes one idle cycle apart
        for (int c = 0; c < 8; c++) begin
            wr(`CCK_OFS_GP_SRC, c[7:0]);
            wr(`CCK_OFS_GP_DIV, 8'h83);
            measure(1'b0, (c < 6) ? 3 * 2 * (c + 4) : 0);
        end
        // divide field boundaries on the first source
        wr(`CCK_OFS_GP_SRC, 8'h00);
        wr(`CCK_OFS_GP_DIV, 8'h80);
        measure(1'b0, 128 * 8);
        wr(`CCK_OFS_GP_DIV, 8'hff);
        measure(1'b0, 127 * 8);
        wr(`CCK_OFS_GP_DIV, 8'h81);
        measure(1'b0, 8);
        wr(`CCK_OFS_GP_DIV, 8'h03);
        rd(`CCK_OFS_GP_DIV, 8'h03);
        measure(1'b0, 0);
        // auto mode follows detection, manual fields ignored
        wr(`CCK_OFS_CONV, 8'h07);
        for (int c = 0; c < 4; c++) begin
            det_ratio = c[1:0];
            det_osc = 1'b0;
            measure(1'b1, 20 << c);
            det_osc = 1'b1;
            measure(1'b1, 16 << c);
        end
        // manual source, enable and ratio
        for (int c = 0; c < 4; c++) begin
            wr(`CCK_OFS_CONV, 8'h2c | c[7:0]);
            measure(1'b1, 20 << c);
            wr(`CCK_OFS_CONV, 8'h3c | c[7:0]);
            measure(1'b1, 16 << c);
        end
        wr(`CCK_OFS_CONV, 8'h28);
        measure(1'b1, 0);
        // frequency mode codes and the direct oscillator restriction
        for (int c = 0; c < 4; c++) begin
            wr(`CCK_OFS_CONV, {c[1:0], 6'h2c});
            rd(`CCK_OFS_CONV, {c[1:0], 6'h2c});
            cmp8({6'h0, freq_mode}, {6'h0, c[1:0]});
            cmp8({7'h0, mode_err}, {7'h0, c == 3});
        end
        wr(`CCK_OFS_CONV, 8'hfc);
        @(posedge clk);
        #1 cmp8({7'h0, mode_err}, 8'h00);
        wr(`CCK_OFS_CONV, 8'hc0);
        @(posedge clk);
        #1 cmp8({7'h0, mode_err}, 8'h01);
        end_sim();
    end

endmodule

`default_nettype wire
